// ---- inc/uirq_pkg.sv ----
package uirq_pkg;
    // Register byte offsets.
    localparam logic [7:0] UIRQ_ENABLE_OFS = 8'h04;
    localparam logic [7:0] UIRQ_IDENT_OFS = 8'h08;
    // Fifo control field positions.
    localparam int UIRQ_FC_EN_BIT = 0;
    localparam int UIRQ_FC_RX_FIFO_CLEAR_BIT = 1;
    localparam int UIRQ_FC_TX_FIFO_CLEAR_BIT = 2;
    localparam int UIRQ_FC_DMA1_BIT = 3;
    localparam int UIRQ_FC_TRIG_LSB = 6;
    // Interrupt enable field positions.
    localparam int UIRQ_IE_RX_BIT = 0;
    localparam int UIRQ_IE_TX_BIT = 1;
    localparam int UIRQ_IE_LS_BIT = 2;
    // Identification field positions.
    localparam int UIRQ_ID_PEND_BIT = 0;
    localparam int UIRQ_ID_TYPE_LSB = 1;
    localparam int UIRQ_ID_MODE_LSB = 6;
    // Reset values.
    localparam logic [1:0] UIRQ_TRIG_RESET = 2'h0;
    localparam logic [2:0] UIRQ_IE_RESET = 3'h0;
    // Interrupt type codes.
    localparam logic [2:0] UIRQ_ID_NONE = 3'h0;
    localparam logic [2:0] UIRQ_ID_THRE = 3'h1;
    localparam logic [2:0] UIRQ_ID_RDR = 3'h2;
    localparam logic [2:0] UIRQ_ID_LS = 3'h3;
    localparam logic [2:0] UIRQ_ID_TO = 3'h6;
    localparam logic [1:0] UIRQ_MODE_FIFO = 2'h3;
    // Receive time-out length in character times.
    localparam logic [2:0] UIRQ_CHAR_TIMES = 3'h4;
    // Receive trigger thresholds in bytes.
    localparam logic [4:0] UIRQ_TRIG_L0 = 5'h01;
    localparam logic [4:0] UIRQ_TRIG_L1 = 5'h04;
    localparam logic [4:0] UIRQ_TRIG_L2 = 5'h08;
    localparam logic [4:0] UIRQ_TRIG_L3 = 5'h0e;

    function automatic logic [4:0] uirq_trig_bytes(input logic [1:0] code);
        logic [4:0] r;
        r = UIRQ_TRIG_L0;
        unique case (code)
            2'h0: r = UIRQ_TRIG_L0;
            2'h1: r = UIRQ_TRIG_L1;
            2'h2: r = UIRQ_TRIG_L2;
            2'h3: r = UIRQ_TRIG_L3;
        endcase
        return r;
    endfunction : uirq_trig_bytes
endpackage : uirq_pkg

// ---- design/uirq_top.sv ----
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
// How it works
// - line errors raise top-priority line status interrupt
// - overrun cause cleared by line status read
// - error cause held until errored characters read
// - non-fifo: waiting character raises data ready
// - non-fifo: buffer read clears data ready
// - fifo: fill reaching trigger raises data ready
// - fifo: four idle character times reassert interrupt
// - fifo: fill below trigger clears data ready
// - fifo: idle non-empty fifo raises time-out
// - time-out cleared by read, push, receiver reset
// - transmit empty raises lowest-priority interrupt
// - transmit write clears transmit-empty interrupt
// - first cpu or dma read clears time-out interrupt
// - shared address: read identifies, write controls
// - other control bits need fifo enable set
// - control field layout, all resetting to zero
// - pending flag low while enabled interrupt pending
// - trigger codes select 1, 4, 8, 14
// - clear bits empty fifo, self-return zero
// - disabling fifos clears pointers and counters
module uirq_top
    import uirq_pkg::*;
#(
    parameter int CNT_W = 5
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CNT_W-1:0] rx_count,
    input wire logic rx_push,
    input wire logic rx_push_err,
    input wire logic rx_read_cpu,
    input wire logic rx_read_dma,
    input wire logic rx_pop_err,
    input wire logic overrun_in,
    input wire logic lsr_read,
    input wire logic char_tick,
    input wire logic receiver_reset_n,
    input wire logic tx_empty,
    input wire logic thr_write,
    output logic fifo_enable,
    output logic dma_mode_one,
    output logic [1:0] rx_trigger_level,
    output logic rx_fifo_clear,
    output logic tx_fifo_clear,
    output logic irq
);
    typedef struct packed {
        logic [2:0] ie;
        logic fifo_en;
        logic dma1;
        logic [1:0] trig;
        logic rx_clr;
        logic tx_clr;
        logic [CNT_W-1:0] err_cnt;
        logic overrun;
        logic [2:0] idle_ticks;
        logic timeout;
        logic thre;
        logic tx_empty_q;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } uirq_state_t;

    uirq_state_t state_reg;
    uirq_state_t state_next;
    logic [2:0] id_code;
    logic ls_pend;
    logic rdr_pend;
    logic rx_pop;
    logic setup;
    logic done;
    logic hit_ie;
    logic hit_id;

    assign rx_pop = rx_read_cpu | rx_read_dma;
    assign setup = psel & ~penable;
    assign done = psel & penable & state_reg.ready;
    assign hit_ie = (paddr == UIRQ_ENABLE_OFS);
    assign hit_id = (paddr == UIRQ_IDENT_OFS);
    assign ls_pend = state_reg.overrun | (state_reg.err_cnt != '0);

    // Data ready follows the fill level, so draining by either reader clears it at once.
    always_comb
    begin
        if (state_reg.fifo_en)
        begin
            rdr_pend = ({{(8-CNT_W){1'b0}}, rx_count} >=
                        {3'h0, uirq_trig_bytes(state_reg.trig)});
        end
        else
        begin
            rdr_pend = (rx_count != '0);
        end
    end

    always_comb
    begin
        id_code = UIRQ_ID_NONE;
        if (state_reg.ie[UIRQ_IE_LS_BIT] && ls_pend)
        begin
            id_code = UIRQ_ID_LS;
        end
        else if (state_reg.ie[UIRQ_IE_RX_BIT] && state_reg.timeout)
        begin
            id_code = UIRQ_ID_TO;
        end
        else if (state_reg.ie[UIRQ_IE_RX_BIT] && rdr_pend)
        begin
            id_code = UIRQ_ID_RDR;
        end
        else if (state_reg.ie[UIRQ_IE_TX_BIT] && state_reg.thre)
        begin
            id_code = UIRQ_ID_THRE;
        end
    end

    always_comb
    begin
        logic fc_wr;
        logic clr_rx;
        logic thre_set;
        fc_wr = 1'b0;
        clr_rx = 1'b0;
        thre_set = 1'b0;
        state_next = state_reg;
        state_next.rx_clr = 1'b0;
        state_next.tx_clr = 1'b0;
        state_next.ready = 1'b0;
        state_next.slverr = 1'b0;
        // The answer is prepared in the setup cycle so that prdata comes from a flop.
        if (setup)
        begin
            state_next.ready = 1'b1;
            state_next.slverr = ~(hit_ie | hit_id);
            state_next.rdata = '0;
            if (!pwrite && hit_ie)
            begin
                state_next.rdata[2:0] = state_reg.ie;
            end
            else if (!pwrite && hit_id)
            begin
                state_next.rdata[UIRQ_ID_MODE_LSB +: 2] =
                    state_reg.fifo_en ? UIRQ_MODE_FIFO : 2'h0;
                state_next.rdata[UIRQ_ID_TYPE_LSB +: 3] = id_code;
                state_next.rdata[UIRQ_ID_PEND_BIT] = (id_code == UIRQ_ID_NONE);
            end
        end
        if (done && pwrite && hit_ie)
        begin
            state_next.ie = pwdata[2:0];
        end
        fc_wr = done && pwrite && hit_id;
        if (fc_wr)
        begin
            state_next.fifo_en = pwdata[UIRQ_FC_EN_BIT];
            // A write that only now sets the enable leaves the other fields untouched.
            if (state_reg.fifo_en)
            begin
                state_next.trig = pwdata[UIRQ_FC_TRIG_LSB +: 2];
                state_next.dma1 = pwdata[UIRQ_FC_DMA1_BIT];
                state_next.rx_clr = pwdata[UIRQ_FC_RX_FIFO_CLEAR_BIT];
                state_next.tx_clr = pwdata[UIRQ_FC_TX_FIFO_CLEAR_BIT];
            end
            if (!pwdata[UIRQ_FC_EN_BIT])
            begin
                state_next.rx_clr = state_reg.fifo_en;
                state_next.tx_clr = state_reg.fifo_en;
            end
        end
        clr_rx = state_next.rx_clr;
        // Error accounting: a push and pop of errored characters together cancel out.
        if (clr_rx)
        begin
            state_next.err_cnt = '0;
        end
        else if (rx_push && rx_push_err && !(rx_pop && rx_pop_err))
        begin
            state_next.err_cnt = CNT_W'(state_reg.err_cnt + 1'b1);
        end
        else if (rx_pop && rx_pop_err && !(rx_push && rx_push_err) &&
                 (state_reg.err_cnt != '0))
        begin
            state_next.err_cnt = CNT_W'(state_reg.err_cnt - 1'b1);
        end
        // Overrun set wins over the clearing read.
        if (overrun_in)
        begin
            state_next.overrun = 1'b1;
        end
        else if (lsr_read)
        begin
            state_next.overrun = 1'b0;
        end
        // Idle timer counts character times with no fifo traffic.
        if (rx_push || rx_pop || clr_rx || !state_reg.fifo_en || rx_count == '0)
        begin
            state_next.idle_ticks = '0;
        end
        else if (char_tick && state_reg.idle_ticks != UIRQ_CHAR_TIMES)
        begin
            state_next.idle_ticks = 3'(state_reg.idle_ticks + 1'b1);
        end
        if (rx_push || rx_pop || !receiver_reset_n || clr_rx || !state_reg.fifo_en)
        begin
            state_next.timeout = 1'b0;
        end
        else if (state_reg.idle_ticks == UIRQ_CHAR_TIMES && rx_count != '0)
        begin
            state_next.timeout = 1'b1;
        end
        // Empty transmitter sets the flag on its rising edge; that set beats a write.
        state_next.tx_empty_q = tx_empty;
        thre_set = tx_empty && !state_reg.tx_empty_q;
        if (thre_set)
        begin
            state_next.thre = 1'b1;
        end
        else if (thr_write)
        begin
            state_next.thre = 1'b0;
        end
        state_next.irq = (id_code != UIRQ_ID_NONE);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
            state_reg.ie <= UIRQ_IE_RESET;
            state_reg.trig <= UIRQ_TRIG_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.slverr;
    assign fifo_enable = state_reg.fifo_en;
    assign dma_mode_one = state_reg.dma1;
    assign rx_trigger_level = state_reg.trig;
    assign rx_fifo_clear = state_reg.rx_clr;
    assign tx_fifo_clear = state_reg.tx_clr;
    assign irq = state_reg.irq;

    ls_priority_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg.ie[UIRQ_IE_LS_BIT] && ls_pend) |-> id_code == UIRQ_ID_LS)
        else $error("line status not reported first");

    overrun_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (lsr_read && !overrun_in) |=> !state_reg.overrun)
        else $error("overrun cause not cleared by line status read");

    error_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_push && rx_push_err && !state_next.rx_clr) |=> ls_pend)
        else $error("errored character did not hold line status");

    trig_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg.fifo_en && state_reg.trig == 2'h2 && rx_count >= CNT_W'(8) &&
         state_reg.ie[UIRQ_IE_RX_BIT] && !(state_reg.ie[UIRQ_IE_LS_BIT] && ls_pend))
        |-> (id_code == UIRQ_ID_RDR || id_code == UIRQ_ID_TO))
        else $error("trigger level reached without data ready");

    timeout_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg.fifo_en && state_reg.idle_ticks == UIRQ_CHAR_TIMES && rx_count != '0 &&
         !rx_push && !rx_pop && receiver_reset_n && !state_next.rx_clr && state_next.fifo_en)
        |=> state_reg.timeout)
        else $error("time-out not raised after idle character times");

    timeout_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_push || rx_read_dma || !receiver_reset_n) |=> !state_reg.timeout)
        else $error("time-out not cleared");

    thre_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (thr_write && !(tx_empty && !state_reg.tx_empty_q)) |=> !state_reg.thre)
        else $error("transmit empty not cleared by write");

    ctrl_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!state_reg.fifo_en) |=> $stable(state_reg.trig) && !state_reg.rx_clr)
        else $error("control bits changed with fifos disabled");

    pend_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_id) |=>
        prdata[UIRQ_ID_PEND_BIT] == ($past(id_code) == UIRQ_ID_NONE) && pready)
        else $error("pending flag wrong on identification read");

    clear_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_fifo_clear |-> (state_reg.err_cnt == '0) ##1 !rx_fifo_clear)
        else $error("fifo clear did not self-return");

    disable_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && hit_id && !pwdata[0] && state_reg.fifo_en) |=>
        rx_fifo_clear && tx_fifo_clear && !fifo_enable)
        else $error("disabling fifos did not clear them");
endmodule : uirq_top

// ---- bench/uirq_host.sv ----
`timescale 1ns/100ps
// Register-bus master acting for the host processor; DMA reads are pulsed directly on rx_read_dma.
module uirq_host
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Waits for pready however late it comes; the bench watchdog ends a hang.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep looking like the last request.
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : uirq_host

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import uirq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic fifo_enable, dma_mode_one, rx_fifo_clear, tx_fifo_clear, receiver_reset_n, tx_empty;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [1:0] rx_trigger_level;
    logic [4:0] rx_count;
    logic [8:0] pv;
    int n_mismatch, samples_checked;
    int tl[4] = '{1, 4, 8, 14};
    localparam logic [8:0] PUSH = 9'h001, PERR = 9'h002, RCPU = 9'h004, RDMA = 9'h008;
    localparam logic [8:0] POPE = 9'h010, OVR = 9'h020, LINE_STATUS_REGISTER = 9'h040, TICK = 9'h080;
    localparam logic [8:0] THRW = 9'h100;

    uirq_host i_uirq_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    uirq_top i_uirq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_count(rx_count), .rx_push(pv[0]), .rx_push_err(pv[1]),
        .rx_read_cpu(pv[2]), .rx_read_dma(pv[3]), .rx_pop_err(pv[4]), .overrun_in(pv[5]),
        .lsr_read(pv[6]), .char_tick(pv[7]), .receiver_reset_n(receiver_reset_n),
        .tx_empty(tx_empty), .thr_write(pv[8]), .fifo_enable(fifo_enable),
        .dma_mode_one(dma_mode_one), .rx_trigger_level(rx_trigger_level),
        .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear), .irq(irq));

    always #25 pclk = ~pclk;

    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task stop_test;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task wr(input logic [7:0] a, input logic [31:0] v);
        i_uirq_host.xfer(1'b1, a, v, d, e);
    endtask : wr

    task pulse(input logic [8:0] m);
        @(posedge pclk) pv <= m;
        @(posedge pclk) pv <= 9'h000;
    endtask : pulse

    // Identification word: mode in 7:6, type in 3:1, pending flag low while a type shows.
    task ck_id(input logic [2:0] t, input logic f);
        repeat (2) @(posedge pclk);
        i_uirq_host.xfer(1'b0, UIRQ_IDENT_OFS, 32'h0, d, e);
        chk("ident", {24'h0, f ? UIRQ_MODE_FIFO : 2'h0, 2'h0, t, t == UIRQ_ID_NONE}, d);
        chk("slverr", 32'h0, {31'h0, e});
        chk("irq", {31'h0, t != UIRQ_ID_NONE}, {31'h0, irq});
    endtask : ck_id

    initial
    begin
        repeat (6000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        pv = 9'h000;
        rx_count = 5'h00;
        receiver_reset_n = 1'b1;
        tx_empty = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk("fc", 32'h0, {28'h0, fifo_enable, dma_mode_one, rx_trigger_level});
        ck_id(UIRQ_ID_NONE, 1'b0);
        i_uirq_host.xfer(1'b0, 8'h3c, 32'h0, d, e);
        chk("unmapped", 32'h1, {31'h0, e});
        i_uirq_host.xfer(1'b0, UIRQ_ENABLE_OFS, 32'h0, d, e);
        chk("enable", 32'h0, d);
        wr(UIRQ_ENABLE_OFS, 32'h7);
        i_uirq_host.xfer(1'b0, UIRQ_ENABLE_OFS, 32'h0, d, e);
        chk("enable", 32'h7, d);
        ck_id(UIRQ_ID_THRE, 1'b0);
        @(posedge pclk) rx_count <= 5'h01;
        pulse(PUSH);
        ck_id(UIRQ_ID_RDR, 1'b0);
        pulse(OVR);
        ck_id(UIRQ_ID_LS, 1'b0);
        pulse(LINE_STATUS_REGISTER);
        ck_id(UIRQ_ID_RDR, 1'b0);
        @(posedge pclk) rx_count <= 5'h00;
        pulse(RCPU);
        ck_id(UIRQ_ID_THRE, 1'b0);
        @(posedge pclk) tx_empty <= 1'b0;
        pulse(THRW);
        ck_id(UIRQ_ID_NONE, 1'b0);
        @(posedge pclk) rx_count <= 5'h01;
        pulse(PUSH | PERR);
        pulse(LINE_STATUS_REGISTER);
        ck_id(UIRQ_ID_LS, 1'b0);
        @(posedge pclk) rx_count <= 5'h00;
        pulse(RCPU | POPE);
        ck_id(UIRQ_ID_NONE, 1'b0);
        wr(UIRQ_IDENT_OFS, 32'hc9);
        #1 chk("fc", 32'h8, {28'h0, fifo_enable, dma_mode_one, rx_trigger_level});
        wr(UIRQ_IDENT_OFS, 32'hc9);
        #1 chk("fc", 32'hf, {28'h0, fifo_enable, dma_mode_one, rx_trigger_level});
        ck_id(UIRQ_ID_NONE, 1'b1);
        for (int c = 0; c < 4; c++)
        begin
            wr(UIRQ_IDENT_OFS, {24'h0, 2'(c), 6'h09});
            @(posedge pclk) rx_count <= 5'(tl[c] - 1);
            ck_id(UIRQ_ID_NONE, 1'b1);
            @(posedge pclk) rx_count <= 5'(tl[c]);
            ck_id(UIRQ_ID_RDR, 1'b1);
        end
        @(posedge pclk) rx_count <= 5'd13;
        ck_id(UIRQ_ID_NONE, 1'b1);
        repeat (3) pulse(TICK);
        ck_id(UIRQ_ID_NONE, 1'b1);
        pulse(TICK);
        ck_id(UIRQ_ID_TO, 1'b1);
        @(posedge pclk) rx_count <= 5'd12;
        pulse(RDMA);
        ck_id(UIRQ_ID_NONE, 1'b1);
        repeat (4) pulse(TICK);
        @(posedge pclk) receiver_reset_n <= 1'b0;
        ck_id(UIRQ_ID_NONE, 1'b1);
        @(posedge pclk) receiver_reset_n <= 1'b1;
        wr(UIRQ_IDENT_OFS, 32'hcf);
        #1 chk("clears", 32'h3, {30'h0, rx_fifo_clear, tx_fifo_clear});
        @(posedge pclk);
        #1 chk("clears", 32'h0, {30'h0, rx_fifo_clear, tx_fifo_clear});
        @(posedge pclk) rx_count <= 5'h00;
        wr(UIRQ_IDENT_OFS, 32'h8);
        #1 chk("disable", 32'h3, {29'h0, fifo_enable, rx_fifo_clear, tx_fifo_clear});
        ck_id(UIRQ_ID_NONE, 1'b0);
        @(posedge pclk) tx_empty <= 1'b1;
        ck_id(UIRQ_ID_THRE, 1'b0);
        stop_test();
    end
endmodule : testbench
